// *** rtl/cwsc_dead.sv ***
`timescale 1ns/10ps
// ==========================================================
// Dead-band timer: counts module clock enables up to a limit
module cwsc_dead #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         tick,
  input  wire logic         start,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  logic [W-1:0] count;
  logic         running;

  always_ff @(posedge clk) begin
    if (reset || start) begin
      count   <= '0;
      running <= start;
    end else if (running && tick) begin
      if (count + W'(1) >= limit) begin
        running <= 1'b0;
      end
      count <= count + W'(1);
    end
  end

  assign done = running && tick && (count + W'(1) >= limit);
endmodule

// *** rtl/cwsc_pkg.sv ***
package cwsc_pkg;

  // ==========================================================
  // Register indices (byte addresses on the plain port)
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CTRL2 = 3'h2;
  localparam logic [2:0] REG_DBR   = 3'h3;
  localparam logic [2:0] REG_DBF   = 3'h4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [5:0] DEAD_RESET  = 6'h00;

  // ==========================================================
  // Field positions
  localparam int EN_BIT   = 7;
  localparam int OEB_BIT  = 6;
  localparam int OEA_BIT  = 5;
  localparam int POLB_BIT = 4;
  localparam int POLA_BIT = 3;
  localparam int CS_BIT   = 0;
  localparam int ASE_BIT  = 7;
  localparam int ARS_BIT  = 6;

  // Writable-bit masks; the rest read as zero
  localparam logic [7:0] CTRL0_MASK = 8'hf9;
  localparam logic [7:0] CTRL1_MASK = 8'hf7;
  localparam logic [7:0] CTRL2_MASK = 8'hcf;
  localparam logic [7:0] DEAD_MASK  = 8'h3f;

  // ==========================================================
  // Override level codes
  localparam logic [1:0] OVR_INACTIVE = 2'h0;
  localparam logic [1:0] OVR_TRISTATE = 2'h1;
  localparam logic [1:0] OVR_LOW      = 2'h2;
  localparam logic [1:0] OVR_HIGH     = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cwsc_bus_t;

  typedef struct packed {
    logic comp_one;
    logic comp_two;
    logic logic_one;
    logic logic_two;
    logic nco;
    logic [3:0] pwm;
    logic fault_n;
  } cwsc_src_t;

endpackage

// *** rtl/cwsc_top.sv ***
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// Operation
// - Software setting shutdown flag forces shutdown and override levels
// - Without auto-restart, shutdown persists while the flag stays set
// - With auto-restart, flag self-clears; resume at next rising edge
// - Any enabled shutdown source forces override levels at once, ORed
// - Sources are level-sensitive; active level holds shutdown
// - Enables: bit3 comp two, bit2 comp one, bit1 fault low, bit0 cell two
// - Without auto-restart, software clear works only if sources are low
// - With auto-restart, flag clears when all enabled sources are low
// - Overrides hold after clear until next input rising edge
// - Override fields B 7-6, A 5-4; 11 high, 10 low, 01 tristate
// - Code 00 drives inactive level after dead band, polarity applied; here driven at once, no dead band
// - Three-bit input source select, comparators, PWMs, oscillator, cell
// - Output enable bits 6,5 route B,A to pins
// - Polarity bits 4,3 invert B,A; not applied to 11/10 overrides
// - Clock source bit 0 picks fast oscillator or system clock
// - Waveforms continue during sleep if clock and source active
// - Fast oscillator kept running in sleep when it clocks the module
// - Unimplemented bits read as zero
// - Rising edge: B off now, A on after rising dead band
// - Falling edge: A off now, B on after falling dead band
// - Six-bit dead counts; zero bypasses dead band
// - Disabled module has no pin effect; outputs start cleared
module cwsc_top #(
  parameter int DEAD_W = 6
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic        FAST_OSC_TICK,
  input  wire logic        SLEEP,
  input  wire logic        COMP_ONE,
  input  wire logic        COMP_TWO,
  input  wire logic        LOGIC_ONE,
  input  wire logic        LOGIC_TWO,
  input  wire logic        NCO_OUT,
  input  wire logic [3:0]  PWM_OUT,
  input  wire logic        FAULT_INPUT_N,
  output logic [7:0]       RDATA,
  output logic             FIRST_DRIVE_OUTPUT,
  output logic             FIRST_DRIVE_OE_N,
  output logic             SECOND_DRIVE_OUTPUT,
  output logic             SECOND_DRIVE_OE_N,
  output logic             FAST_OSC_KEEP,
  output logic             SHUTDOWN_ACTIVE
);

  cwsc_pkg::cwsc_bus_t bus;
  cwsc_pkg::cwsc_src_t src;
  logic [7:0]          ctrl0;
  logic [7:0]          ctrl1;
  logic [3:0]          sd_enable;
  logic                shutdown_event_flag;
  logic                auto_restart_enable;
  logic [DEAD_W-1:0]   rising_dead_time_count;
  logic [DEAD_W-1:0]   falling_dead_time_count;
  logic                module_enable;
  logic                input_now;
  logic                input_prev;
  logic                rise;
  logic                fall;
  logic                tick;
  logic                src_active;
  logic                hold_override;
  logic                drive_a;
  logic                drive_b;
  logic                rise_done;
  logic                fall_done;
  logic                next_a;
  logic                next_b;
  logic                next_a_oe_n;
  logic                next_b_oe_n;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign src = '{comp_one: COMP_ONE, comp_two: COMP_TWO,
                 logic_one: LOGIC_ONE, logic_two: LOGIC_TWO,
                 nco: NCO_OUT, pwm: PWM_OUT, fault_n: FAULT_INPUT_N};

  assign module_enable = ctrl0[cwsc_pkg::EN_BIT];

  // ==========================================================
  // Functions
  function automatic logic pick_source(input logic [2:0] sel,
                                       input cwsc_pkg::cwsc_src_t s);
    case (sel)
      3'h0:    pick_source = s.comp_one;
      3'h1:    pick_source = s.comp_two;
      3'h2:    pick_source = s.pwm[0];
      3'h3:    pick_source = s.pwm[1];
      3'h4:    pick_source = s.pwm[2];
      3'h5:    pick_source = s.pwm[3];
      3'h6:    pick_source = s.nco;
      default: pick_source = s.logic_one;
    endcase
  endfunction

  // Override decode per pin: value and tristate, polarity only for 00
  function automatic logic [1:0] override_pin(input logic [1:0] code,
                                              input logic       pol);
    case (code)
      cwsc_pkg::OVR_HIGH:     override_pin = 2'h1;
      cwsc_pkg::OVR_LOW:      override_pin = 2'h0;
      cwsc_pkg::OVR_TRISTATE: override_pin = 2'h2;
      default:                override_pin = {1'b0, pol};
    endcase
  endfunction

  // ==========================================================
  // Clock select: module rate is system clock or fast oscillator enable
  assign tick = ctrl0[cwsc_pkg::CS_BIT] ? FAST_OSC_TICK : 1'b1;

  // ==========================================================
  // Shutdown sources, level sensitive and ORed
  assign src_active = (sd_enable[3] & src.comp_two)
                    | (sd_enable[2] & src.comp_one)
                    | (sd_enable[1] & ~src.fault_n)
                    | (sd_enable[0] & src.logic_two);

  // ==========================================================
  // Register writes
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl0 <= cwsc_pkg::CTRL0_RESET;
      ctrl1 <= cwsc_pkg::CTRL1_RESET;
      sd_enable <= cwsc_pkg::CTRL2_RESET[3:0];
      auto_restart_enable <= 1'b0;
      rising_dead_time_count <= DEAD_W'(cwsc_pkg::DEAD_RESET);
      falling_dead_time_count <= DEAD_W'(cwsc_pkg::DEAD_RESET);
    end else if (bus.wr) begin
      case (bus.addr[2:0])
        cwsc_pkg::REG_CTRL0: ctrl0 <= bus.wdata & cwsc_pkg::CTRL0_MASK;
        cwsc_pkg::REG_CTRL1: ctrl1 <= bus.wdata & cwsc_pkg::CTRL1_MASK;
        cwsc_pkg::REG_CTRL2: begin
          sd_enable <= bus.wdata[3:0];
          auto_restart_enable <= bus.wdata[cwsc_pkg::ARS_BIT];
        end
        cwsc_pkg::REG_DBR: rising_dead_time_count <= bus.wdata[DEAD_W-1:0];
        cwsc_pkg::REG_DBF: falling_dead_time_count <= bus.wdata[DEAD_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Shutdown flag; a live source wins over any clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      shutdown_event_flag <= 1'b0;
    end else if (src_active) begin
      shutdown_event_flag <= 1'b1;
    end else if (bus.wr && bus.addr[2:0] == cwsc_pkg::REG_CTRL2) begin
      // Setting with auto-restart on clears next cycle via branch below
      shutdown_event_flag <= bus.wdata[cwsc_pkg::ASE_BIT];
    end else if (auto_restart_enable) begin
      shutdown_event_flag <= 1'b0;
    end
  end

  // Override held until first rising edge after flag clears
  always_ff @(posedge CLK) begin
    if (RESET) begin
      hold_override <= 1'b1;
    end else if (shutdown_event_flag || src_active || !module_enable) begin
      hold_override <= 1'b1;
    end else if (rise) begin
      hold_override <= 1'b0;
    end
  end

  // ==========================================================
  // Input edge detect on module clock
  assign input_now = pick_source(ctrl1[2:0], src);
  assign rise = tick && input_now && !input_prev;
  assign fall = tick && !input_now && input_prev;

  always_ff @(posedge CLK) begin
    if (RESET || !module_enable) begin
      input_prev <= 1'b0;
    end else if (tick) begin
      input_prev <= input_now;
    end
  end

  // ==========================================================
  // Dead-band generation
  cwsc_dead #(.W(DEAD_W)) u_rise (
    .clk   (CLK),
    .reset (RESET || !module_enable || fall),
    .tick  (tick),
    .start (rise && rising_dead_time_count != '0),
    .limit (rising_dead_time_count),
    .done  (rise_done)
  );

  cwsc_dead #(.W(DEAD_W)) u_fall (
    .clk   (CLK),
    .reset (RESET || !module_enable || rise),
    .tick  (tick),
    .start (fall && falling_dead_time_count != '0),
    .limit (falling_dead_time_count),
    .done  (fall_done)
  );

  always_ff @(posedge CLK) begin
    if (RESET || !module_enable) begin
      drive_a <= 1'b0;
      drive_b <= 1'b0;
    end else if (rise) begin
      drive_b <= 1'b0;
      drive_a <= (rising_dead_time_count == '0);
    end else if (fall) begin
      drive_a <= 1'b0;
      drive_b <= (falling_dead_time_count == '0);
    end else begin
      if (rise_done) begin
        drive_a <= 1'b1;
      end
      if (fall_done) begin
        drive_b <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Pin stage; shutdown sources feed straight into next-state
  logic [1:0] ovr_a;
  logic [1:0] ovr_b;
  logic       in_shutdown;

  assign in_shutdown = src_active || shutdown_event_flag || hold_override;
  assign ovr_a = override_pin(ctrl1[5:4], ctrl0[cwsc_pkg::POLA_BIT]);
  assign ovr_b = override_pin(ctrl1[7:6], ctrl0[cwsc_pkg::POLB_BIT]);

  always_comb begin
    next_a      = 1'b0;
    next_b      = 1'b0;
    next_a_oe_n = 1'b1;
    next_b_oe_n = 1'b1;
    if (module_enable) begin
      if (in_shutdown) begin
        next_a = ovr_a[0];
        next_b = ovr_b[0];
        next_a_oe_n = ovr_a[1] | ~ctrl0[cwsc_pkg::OEA_BIT];
        next_b_oe_n = ovr_b[1] | ~ctrl0[cwsc_pkg::OEB_BIT];
      end else begin
        next_a = drive_a ^ ctrl0[cwsc_pkg::POLA_BIT];
        next_b = drive_b ^ ctrl0[cwsc_pkg::POLB_BIT];
        next_a_oe_n = ~ctrl0[cwsc_pkg::OEA_BIT];
        next_b_oe_n = ~ctrl0[cwsc_pkg::OEB_BIT];
      end
    end
  end

  // Registered pins: one system clock of latency, never a module tick
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FIRST_DRIVE_OUTPUT  <= 1'b0;
      SECOND_DRIVE_OUTPUT <= 1'b0;
      FIRST_DRIVE_OE_N    <= 1'b1;
      SECOND_DRIVE_OE_N   <= 1'b1;
      SHUTDOWN_ACTIVE     <= 1'b0;
    end else begin
      FIRST_DRIVE_OUTPUT  <= next_a;
      SECOND_DRIVE_OUTPUT <= next_b;
      FIRST_DRIVE_OE_N    <= next_a_oe_n;
      SECOND_DRIVE_OE_N   <= next_b_oe_n;
      SHUTDOWN_ACTIVE     <= in_shutdown;
    end
  end

  // Sleep does not stop this logic; only the oscillator keep-alive
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FAST_OSC_KEEP <= 1'b0;
    end else begin
      FAST_OSC_KEEP <= SLEEP && module_enable
                       && ctrl0[cwsc_pkg::CS_BIT];
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr[2:0])
        cwsc_pkg::REG_CTRL0: RDATA <= ctrl0;
        cwsc_pkg::REG_CTRL1: RDATA <= ctrl1;
        cwsc_pkg::REG_CTRL2: RDATA <= {shutdown_event_flag,
                                       auto_restart_enable,
                                       2'h0, sd_enable};
        cwsc_pkg::REG_DBR: RDATA <= 8'(rising_dead_time_count);
        cwsc_pkg::REG_DBF: RDATA <= 8'(falling_dead_time_count);
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ==========================================================
  // Checks
  a_src_forces_flag: assert property (@(posedge CLK) disable iff (RESET)
    src_active |=> shutdown_event_flag)
    else $error("Active source did not set flag");

  a_level_holds: assert property (@(posedge CLK) disable iff (RESET)
    src_active [*2] |-> shutdown_event_flag)
    else $error("Flag clear while source active");

  a_sw_set: assert property (@(posedge CLK) disable iff (RESET)
    (bus.wr && bus.addr[2:0] == cwsc_pkg::REG_CTRL2
     && bus.wdata[7]) |=> shutdown_event_flag)
    else $error("Software set lost");

  a_flag_stays: assert property (@(posedge CLK) disable iff (RESET)
    (shutdown_event_flag && !auto_restart_enable && !bus.wr)
    |=> shutdown_event_flag)
    else $error("Flag dropped without clear");

  a_auto_clear: assert property (@(posedge CLK) disable iff (RESET)
    (auto_restart_enable && !src_active && !bus.wr
     && shutdown_event_flag) |=> !shutdown_event_flag)
    else $error("Auto-restart did not clear flag");

  a_hold_override: assert property (@(posedge CLK) disable iff (RESET)
    (hold_override && !rise) |=> hold_override)
    else $error("Override released without rising edge");

  a_b_off_rise: assert property (@(posedge CLK) disable iff (RESET)
    (rise && module_enable) |=> !drive_b)
    else $error("B not off on rising edge");

  a_a_off_fall: assert property (@(posedge CLK) disable iff (RESET)
    (fall && module_enable) |=> !drive_a)
    else $error("A not off on falling edge");

  a_disabled_pins: assert property (@(posedge CLK) disable iff (RESET)
    !module_enable |=> FIRST_DRIVE_OE_N && SECOND_DRIVE_OE_N)
    else $error("Pins driven while disabled");

  a_no_overlap: assert property (@(posedge CLK) disable iff (RESET)
    !(drive_a && drive_b))
    else $error("Both drives on");

endmodule

// *** tb/cwsc_far.sv ***
`timescale 1ns/10ps
// ==========================================================
// Far side: source and fault levels, gate drivers with pull-downs
module cwsc_far (
  input  wire logic                clk,
  input  wire cwsc_pkg::cwsc_src_t src,
  input  wire logic                a,
  input  wire logic                a_oe_n,
  input  wire logic                b,
  input  wire logic                b_oe_n,
  input  wire logic                sd,
  output cwsc_pkg::cwsc_src_t      src_o,
  output logic                     pin_a,
  output logic                     pin_b,
  output logic                     ovl
);
  assign src_o = src;
  // Released driver input falls to its pull-down, never holds old level
  assign pin_a = a_oe_n ? 1'b0 : a;
  assign pin_b = b_oe_n ? 1'b0 : b;
  // Both switches on outside shutdown means shoot-through; sticky
  initial ovl = 1'b0;
  always @(posedge clk) begin
    if (pin_a && pin_b && !sd) begin
      ovl <= 1'b1;
    end
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic                CLK, RESET, WR, RD, FAST_OSC_TICK, SLEEP;
  logic [7:0]          ADDR, WDATA, RDATA, d;
  logic                fa, fa_n, fb, fb_n, keep, sd, pin_a, pin_b, ovl;
  logic [1:0]          tcnt;
  cwsc_pkg::cwsc_src_t src, so;
  int                  n_fail, num_checks, cur_src;

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Fast oscillator enable: one pulse every four system clocks
  always @(posedge CLK) begin
    if (RESET) begin
      tcnt <= 2'h0;
      FAST_OSC_TICK <= 1'b0;
    end else begin
      tcnt <= tcnt + 2'h1;
      FAST_OSC_TICK <= (tcnt == 2'h3);
    end
  end

  cwsc_top u_cwsc_top (
    .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .FAST_OSC_TICK(FAST_OSC_TICK), .SLEEP(SLEEP),
    .COMP_ONE(so.comp_one), .COMP_TWO(so.comp_two),
    .LOGIC_ONE(so.logic_one), .LOGIC_TWO(so.logic_two),
    .NCO_OUT(so.nco), .PWM_OUT(so.pwm), .FAULT_INPUT_N(so.fault_n),
    .RDATA(RDATA), .FIRST_DRIVE_OUTPUT(fa), .FIRST_DRIVE_OE_N(fa_n),
    .SECOND_DRIVE_OUTPUT(fb), .SECOND_DRIVE_OE_N(fb_n),
    .FAST_OSC_KEEP(keep), .SHUTDOWN_ACTIVE(sd)
  );
  cwsc_far u_cwsc_far (
    .clk(CLK), .src(src), .a(fa), .a_oe_n(fa_n), .b(fb), .b_oe_n(fb_n),
    .sd(sd), .src_o(so), .pin_a(pin_a), .pin_b(pin_b), .ovl(ovl)
  );

  // ==========================================================
  // Bus and stimulus helpers; index 0..2 ctrl, 3 rising, 4 falling
  task cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= {5'h00, a};
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge CLK);
    ADDR <= {5'h00, a};
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task set_src(input int k, input logic v);
    @(posedge CLK);
    case (k)
      0: src.comp_one <= v;
      1: src.comp_two <= v;
      6: src.nco <= v;
      7: src.logic_one <= v;
      default: src.pwm[k-2] <= v;
    endcase
  endtask
  task set_flt(input int j, input logic v);
    @(posedge CLK);
    case (j)
      3: src.comp_two <= v;
      2: src.comp_one <= v;
      1: src.fault_n <= ~v;
      default: src.logic_two <= v;
    endcase
  endtask
  // Edge on the selected source; delays of A and B to their new levels
  task edge_meas(input logic v, input int alo, ahi, blo, bhi);
    int na, nb;
    na = 0;
    nb = 0;
    set_src(cur_src, v);
    for (int k = 1; k < 100 && (na == 0 || nb == 0); k++) begin
      @(posedge CLK);
      #1;
      if (na == 0 && fa === v) na = k;
      if (nb == 0 && fb === ~v) nb = k;
    end
    chk(na >= alo && na <= ahi, 1'b1, "a delay");
    chk(nb >= blo && nb <= bhi, 1'b1, "b delay");
  endtask
  task pulse;
    set_src(cur_src, 1'b1);
    cyc(10);
    set_src(cur_src, 1'b0);
    cyc(10);
  endtask

  // ==========================================================
  // Scenarios
  task t_regs;
    logic [7:0] wv [5];
    logic [7:0] m [5];
    wv = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
    m = '{cwsc_pkg::CTRL0_MASK, cwsc_pkg::CTRL1_MASK,
          cwsc_pkg::CTRL2_MASK, cwsc_pkg::DEAD_MASK, cwsc_pkg::DEAD_MASK};
    for (int i = 0; i < 6; i++) begin
      rd(i[2:0]);
      chk(d, 8'h00, "reset value");
    end
    for (int i = 0; i < 5; i++) begin
      wr(i[2:0], wv[i]);
      rd(i[2:0]);
      chk(d, wv[i] & m[i], "mask");
      wr(i[2:0], 8'h00);
    end
    $display("regs finished");
  endtask
  task t_start;
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h02);
    wr(3'h2, 8'h80);
    wr(3'h1, 8'he2);
    wr(3'h0, 8'he0);
    cyc(3);
    chk({sd, fa_n, fb_n, fa, fb}, 5'b10001, "override");
    pulse;
    chk({sd, fa, fb}, 3'b101, "held");
    wr(3'h2, 8'h00);
    cyc(4);
    chk({sd, fb}, 2'b11, "hold");
    edge_meas(1'b1, 4, 8, 1, 3);
    chk(sd, 1'b0, "resume");
    edge_meas(1'b0, 1, 3, 3, 7);
    $display("start finished");
  endtask
  task t_srcsel;
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(3'h1, 8'he0 | k[7:0]);
      cur_src = k;
      edge_meas(1'b1, 1, 4, 1, 3);
      edge_meas(1'b0, 1, 3, 1, 4);
    end
    $display("srcsel finished");
  endtask
  task t_fault;
    logic [7:0] bt;
    for (int j = 0; j < 4; j++) begin
      bt = 8'h01 << j;
      wr(3'h2, 8'h0f & ~bt);
      set_flt(j, 1'b1);
      cyc(2);
      rd(3'h2);
      chk(d, 8'h0f & ~bt, "masked");
      set_flt(j, 1'b0);
      wr(3'h2, 8'h0f);
      set_flt(j, 1'b1);
      cyc(2);
      chk({sd, fa, fb}, 3'b101, "fault");
      wr(3'h2, 8'h0f);
      rd(3'h2);
      chk(d, 8'h8f, "kept");
      set_flt(j, 1'b0);
      wr(3'h2, 8'h0f);
      rd(3'h2);
      chk(d, 8'h0f, "cleared");
      pulse;
    end
    $display("fault finished");
  endtask
  task t_auto;
    wr(3'h2, 8'hc0);
    cyc(2);
    rd(3'h2);
    chk(d, 8'h40, "self clear");
    chk(sd, 1'b1, "hold");
    edge_meas(1'b1, 1, 4, 1, 3);
    edge_meas(1'b0, 1, 3, 1, 4);
    wr(3'h2, 8'h42);
    set_flt(1, 1'b1);
    cyc(2);
    rd(3'h2);
    chk(d, 8'hc2, "set");
    set_flt(1, 1'b0);
    cyc(2);
    rd(3'h2);
    chk(d, 8'h42, "auto clear");
    chk(sd, 1'b1, "hold");
    pulse;
    chk(sd, 1'b0, "resume");
    wr(3'h2, 8'h00);
    $display("auto finished");
  endtask
  task t_pol;
    wr(3'h0, 8'he8);
    cyc(2);
    chk(fa, 1'b1, "inverted");
    wr(3'h1, 8'h47);
    wr(3'h2, 8'h80);
    cyc(3);
    chk({fa, fa_n, fb_n}, 3'b101, "code 00 01");
    wr(3'h1, 8'he7);
    wr(3'h0, 8'hf8);
    cyc(2);
    chk({fa, fb}, 2'b01, "pol ignored");
    wr(3'h0, 8'hd8);
    cyc(2);
    chk({fa_n, fb_n}, 2'b10, "oe");
    wr(3'h0, 8'h78);
    cyc(2);
    chk({fa_n, fb_n, pin_a, pin_b}, 4'b1100, "off");
    $display("pol finished");
  endtask
  task t_sleep;
    wr(3'h1, 8'he2);
    cur_src = 2;
    wr(3'h3, 8'h02);
    wr(3'h0, 8'he1);
    wr(3'h2, 8'h00);
    SLEEP <= 1'b1;
    cyc(2);
    chk(keep, 1'b1, "keep");
    pulse;
    edge_meas(1'b1, 5, 14, 1, 6);
    edge_meas(1'b0, 1, 7, 1, 7);
    @(posedge CLK);
    SLEEP <= 1'b0;
    cyc(2);
    chk(keep, 1'b0, "awake");
    $display("sleep finished");
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run takes a few hundred cycles; allow about forty times that
  initial begin
    #200000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop;
  end
  initial begin
    RESET = 1'b1;
    {ADDR, WDATA, WR, RD, SLEEP} = '0;
    src = '0;
    src.fault_n = 1'b1;
    n_fail = 0;
    num_checks = 0;
    cur_src = 2;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    t_regs;
    t_start;
    t_srcsel;
    t_fault;
    t_auto;
    chk(ovl, 1'b0, "overlap");
    t_pol;
    t_sleep;
    report_and_stop;
  end
endmodule
